// ### dv/olr_ctrl_assertions.sv
`default_nettype none
module olr_ctrl_assertions (
	// clock, reset and register port
	input wire logic        clk, reset_n, regWrEn,
	input wire logic [31:0] regWrData, regRdData,
	// controls
	input wire logic        clockDriverAOn, clockDriverBOn, synthLoopAOn, synthLoopBOn, loopARefSel, loopBRefSel
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence wr_loopb_on;
		regWrEn && regWrData[3:2] == 2'h3 ##1 !regWrEn;
	endsequence
	chk_drva_gate: assert property (clockDriverAOn |-> synthLoopBOn) else $error("drv a gate");
	chk_drvb_gate: assert property (clockDriverBOn |-> synthLoopBOn) else $error("drv b gate");
	chk_loopb_view: assert property (synthLoopBOn == &regRdData[3:2]) else $error("loop b");
	chk_loopa_view: assert property (synthLoopAOn == regRdData[1]) else $error("loop a");
	chk_refa_view: assert property (loopARefSel == &regRdData[5:4]) else $error("ref a");
	chk_refb_view: assert property (loopBRefSel == &regRdData[7:6]) else $error("ref b");
	chk_drva_view: assert property (clockDriverAOn == (regRdData[9] && synthLoopBOn)) else $error("drv a");
	chk_drvb_view: assert property (clockDriverBOn == (regRdData[11] && synthLoopBOn)) else $error("drv b");
	chk_loopb_write: assert property (wr_loopb_on |=> synthLoopBOn) else $error("loop b write");
endmodule // olr_ctrl_assertions
`default_nettype wire

// ### dv/olr_ctrl_tb_top.sv
`default_nettype none
module olr_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, reset_n = 0, regWrEn = 0, pA = 0, pB = 0, pD = 0, cA, cB, lA, lB, rA, rB;
	logic [31:0] regWrData = 32'h0, regRdData, exRd;
	logic [11:0] m = 12'h000;
	int          n_mismatch = 0, check_count = 0;
	always #5 clk = ~clk;
	olr_ctrl uut (.clk(clk), .reset_n(reset_n), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
		.driverAEnablePin(pA), .driverBEnablePin(pB), .loopAPowerdownPin(pD), .clockDriverAOn(cA),
		.clockDriverBOn(cB), .synthLoopAOn(lA), .synthLoopBOn(lB), .loopARefSel(rA), .loopBRefSel(rB));
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one optional write plus new pin levels, then compare once settled
	task automatic step(logic [31:0] d, logic w);
		logic [2:0] p;
		logic       b;
		p = 3'($urandom);
		@(posedge clk);
		regWrEn <= w;
		regWrData <= d;
		{pA, pB, pD} <= p;
		if (w) m = {d[10] ? d[11] : m[11], d[10], d[8] ? d[9] : m[9], d[8], d[7:2], d[0] ? d[1] : m[1], d[0]};
		@(posedge clk);
		regWrEn <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		b = m[2] & m[3];
		exRd = {20'h0, m[10] ? m[11] : p[1], m[10], m[8] ? m[9] : p[2], m[8], m[7:2], m[0] ? m[1] : p[0], m[0]};
		chk("rd", regRdData, exRd);
		chk("drvA", cA, exRd[9] & b);
		chk("drvB", cB, exRd[11] & b);
		chk("loopA", lA, exRd[1]);
		chk("loopB", lB, b);
		chk("refA", rA, m[4] & m[5]);
		chk("refB", rB, m[6] & m[7]);
	endtask
	initial begin
		void'($urandom(32'h451B));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		step(32'h0, 1'b0);
		step(32'hC, 1'b1);
		step(32'hF0F, 1'b1);
		step(32'h20C, 1'b1);
		repeat (80) step($urandom, 1'($urandom));
		complete_run();
	end
endmodule // olr_ctrl_tb_top
bind olr_ctrl olr_ctrl_assertions chk_i (.clk, .reset_n, .regWrEn, .regWrData, .regRdData, .clockDriverAOn,
	.clockDriverBOn, .synthLoopAOn, .synthLoopBOn, .loopARefSel, .loopBRefSel);
`default_nettype wire

// ### pkg/olr_regs.vh
`ifndef OLR_REGS_VH
`define OLR_REGS_VH

// register width and implemented field span
`define OLR_REG_WIDTH        32
`define OLR_CTRL_WIDTH       12

// reset value of the implemented control bits
`define OLR_CTRL_RESET       12'h000

// field positions
`define OLR_LOOP_A_POWER_SOURCE_SEL  0
`define OLR_SYNTH_LOOP_A             1
`define OLR_LOOP_B_POWER_GATE        2
`define OLR_SYNTH_LOOP_B             3
`define OLR_LOOP_A_REF_CHOICE_GATE   4
`define OLR_LOOP_A_REF_CHOICE        5
`define OLR_LOOP_B_REF_CHOICE_GATE   6
`define OLR_LOOP_B_REF_CHOICE        7
`define OLR_DRIVER_A_SOURCE_SEL      8
`define OLR_CLOCK_DRIVER_A_EN        9
`define OLR_DRIVER_B_SOURCE_SEL      10
`define OLR_CLOCK_DRIVER_B_EN        11

// reference choice encoding
`define OLR_REF_ONE          1'b0
`define OLR_REF_TWO          1'b1

`endif

// ### verilog/olr_ctrl.v
`include "olr_regs.vh"
`default_nettype none

module olr_ctrl (
	// clock and reset
	input  wire                        clk,
	input  wire                        reset_n,
	// register access
	input  wire                        regWrEn,
	input  wire [`OLR_REG_WIDTH-1:0]   regWrData,
	output reg  [`OLR_REG_WIDTH-1:0]   regRdData,
	// pins
	input  wire                        driverAEnablePin,
	input  wire                        driverBEnablePin,
	input  wire                        loopAPowerdownPin,
	// controls to the analog section
	output reg                         clockDriverAOn,
	output reg                         clockDriverBOn,
	output reg                         synthLoopAOn,
	output reg                         synthLoopBOn,
	output reg                         loopARefSel,
	output reg                         loopBRefSel
);

	// pin-mirrored fields: 0 loop a power, 1 driver a, 2 driver b
	localparam integer RO_COUNT = 3;

	// output values held during reset
	localparam [`OLR_REG_WIDTH-1:0] RD_RESET     = 32'h00000000;
	localparam [0:0]                DRV_A_RESET  = 1'h0;
	localparam [0:0]                DRV_B_RESET  = 1'h0;
	localparam [0:0]                LOOP_A_RESET = 1'h0;
	localparam [0:0]                LOOP_B_RESET = 1'h0;
	localparam [0:0]                REF_A_RESET  = `OLR_REF_ONE;
	localparam [0:0]                REF_B_RESET  = `OLR_REF_ONE;

	// register image, its next value and its read view
	reg  [`OLR_CTRL_WIDTH-1:0] ctrl_reg;
	reg  [`OLR_CTRL_WIDTH-1:0] ctrl_next;
	reg  [`OLR_CTRL_WIDTH-1:0] view;

	// per-field helpers for the pin-mirrored bits
	wire [RO_COUNT-1:0]        roPin;
	wire [RO_COUNT-1:0]        roSelStored;
	wire [RO_COUNT-1:0]        roEnStored;
	wire [RO_COUNT-1:0]        roSelWritten;
	wire [RO_COUNT-1:0]        roEnWritten;
	wire [RO_COUNT-1:0]        roEnKept;
	wire [RO_COUNT-1:0]        roLive;

	// live control sources
	wire                       loopBLive;
	wire                       loopALive;
	wire                       drvASrc;
	wire                       drvBSrc;
	wire                       refALive;
	wire                       refBLive;

	// next values of the output flops
	reg  [`OLR_REG_WIDTH-1:0]  regRdData_next;
	reg                        clockDriverAOn_next;
	reg                        clockDriverBOn_next;
	reg                        synthLoopAOn_next;
	reg                        synthLoopBOn_next;
	reg                        loopARefSel_next;
	reg                        loopBRefSel_next;

	genvar gi;

	// select 1 takes the register bit, select 0 the pin
	function olr_pick;
		input sel;
		input regBit;
		input pinLevel;
		begin
			if (sel)
				olr_pick = regBit;
			else
				olr_pick = pinLevel;
		end
	endfunction

	// gate 1 passes the choice, gate 0 forces the fallback
	function olr_gate;
		input gate;
		input choice;
		input fallback;
		begin
			if (gate)
				olr_gate = choice;
			else
				olr_gate = fallback;
		end
	endfunction

	// enable bit position of pin-mirrored field idx
	function integer olr_ro_en_pos;
		input integer idx;
		begin
			case (idx)
				0:       olr_ro_en_pos = `OLR_SYNTH_LOOP_A;
				1:       olr_ro_en_pos = `OLR_CLOCK_DRIVER_A_EN;
				default: olr_ro_en_pos = `OLR_CLOCK_DRIVER_B_EN;
			endcase
		end
	endfunction

	// select bit position of pin-mirrored field idx
	function integer olr_ro_sel_pos;
		input integer idx;
		begin
			case (idx)
				0:       olr_ro_sel_pos = `OLR_LOOP_A_POWER_SOURCE_SEL;
				1:       olr_ro_sel_pos = `OLR_DRIVER_A_SOURCE_SEL;
				default: olr_ro_sel_pos = `OLR_DRIVER_B_SOURCE_SEL;
			endcase
		end
	endfunction

	// pins in field order
	assign roPin = {driverBEnablePin, driverAEnablePin, loopAPowerdownPin};

	// one slice per pin-mirrored field
	generate
		for (gi = 0; gi < RO_COUNT; gi = gi + 1) begin : g_ro
			assign roSelStored[gi]  = ctrl_reg[olr_ro_sel_pos(gi)];
			assign roEnStored[gi]   = ctrl_reg[olr_ro_en_pos(gi)];
			assign roSelWritten[gi] = regWrData[olr_ro_sel_pos(gi)];
			assign roEnWritten[gi]  = regWrData[olr_ro_en_pos(gi)];
			// written select 0 drops the written enable bit
			assign roEnKept[gi]     = olr_pick(roSelWritten[gi], roEnWritten[gi], roEnStored[gi]);
			assign roLive[gi]       = olr_pick(roSelStored[gi], roEnStored[gi], roPin[gi]);
		end
	endgenerate

	// stored bits; enable bits read-only under the written select keep their value
	always @* begin
		ctrl_next = ctrl_reg;
		if (regWrEn) begin
			ctrl_next = regWrData[`OLR_CTRL_WIDTH-1:0];
			ctrl_next[`OLR_SYNTH_LOOP_A]      = roEnKept[0];
			ctrl_next[`OLR_CLOCK_DRIVER_A_EN] = roEnKept[1];
			ctrl_next[`OLR_CLOCK_DRIVER_B_EN] = roEnKept[2];
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `OLR_CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// live control sources
	assign loopBLive = olr_gate(ctrl_reg[`OLR_LOOP_B_POWER_GATE], ctrl_reg[`OLR_SYNTH_LOOP_B],
		1'h0);
	assign loopALive = roLive[0];
	assign drvASrc   = roLive[1];
	assign drvBSrc   = roLive[2];
	assign refALive  = olr_gate(ctrl_reg[`OLR_LOOP_A_REF_CHOICE_GATE], ctrl_reg[`OLR_LOOP_A_REF_CHOICE],
		`OLR_REF_ONE);
	assign refBLive  = olr_gate(ctrl_reg[`OLR_LOOP_B_REF_CHOICE_GATE], ctrl_reg[`OLR_LOOP_B_REF_CHOICE],
		`OLR_REF_ONE);

	// read view: pin levels replace bits in read-only state
	always @* begin
		view = ctrl_reg;
		view[`OLR_SYNTH_LOOP_A]      = roLive[0];
		view[`OLR_CLOCK_DRIVER_A_EN] = roLive[1];
		view[`OLR_CLOCK_DRIVER_B_EN] = roLive[2];
	end

	// upper fields not implemented, read 0
	always @* begin
		regRdData_next = {{(`OLR_REG_WIDTH-`OLR_CTRL_WIDTH){1'b0}}, view};
	end

	// driver a needs loop b running
	always @* begin
		if (loopBLive)
			clockDriverAOn_next = drvASrc;
		else
			clockDriverAOn_next = 1'h0;
	end

	// driver b needs loop b running
	always @* begin
		if (loopBLive)
			clockDriverBOn_next = drvBSrc;
		else
			clockDriverBOn_next = 1'h0;
	end

	// loop a power
	always @* begin
		synthLoopAOn_next = loopALive;
	end

	// loop b power
	always @* begin
		synthLoopBOn_next = loopBLive;
	end

	// loop a reference
	always @* begin
		if (ctrl_reg[`OLR_LOOP_A_REF_CHOICE_GATE])
			loopARefSel_next = refALive;
		else
			loopARefSel_next = `OLR_REF_ONE;
	end

	// loop b reference
	always @* begin
		if (ctrl_reg[`OLR_LOOP_B_REF_CHOICE_GATE])
			loopBRefSel_next = refBLive;
		else
			loopBRefSel_next = `OLR_REF_ONE;
	end

	// read view
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= RD_RESET;
		end else begin
			regRdData <= regRdData_next;
		end
	end

	// driver a on
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clockDriverAOn <= DRV_A_RESET;
		end else begin
			clockDriverAOn <= clockDriverAOn_next;
		end
	end

	// driver b on
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clockDriverBOn <= DRV_B_RESET;
		end else begin
			clockDriverBOn <= clockDriverBOn_next;
		end
	end

	// loop a on
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			synthLoopAOn <= LOOP_A_RESET;
		end else begin
			synthLoopAOn <= synthLoopAOn_next;
		end
	end

	// loop b on
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			synthLoopBOn <= LOOP_B_RESET;
		end else begin
			synthLoopBOn <= synthLoopBOn_next;
		end
	end

	// loop a reference select
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loopARefSel <= REF_A_RESET;
		end else begin
			loopARefSel <= loopARefSel_next;
		end
	end

	// loop b reference select
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loopBRefSel <= REF_B_RESET;
		end else begin
			loopBRefSel <= loopBRefSel_next;
		end
	end

endmodule // olr_ctrl

`default_nettype wire
